// ===== rtl/utc_pkg.sv
/*
 * utc_pkg: register map, field positions, reset values and sizes of the
 * serial transceiver register and data port block.
 * assumes: imported by utc_top, utc_top_assertions and utc_top_tb_top, not by the FIFO files or utc_far_model; no timing constants
 * are needed because the block has no waits of its own.
 */
package utc_pkg;

	// ************************************************************
	// sizes
	// ************************************************************
	localparam int ADDR_W     = 4;
	localparam int DATA_W     = 8;
	localparam int WORD_W     = 9;            // data byte plus ninth bit
	localparam int FIFO_DEPTH = 8;
	localparam int ERR_N      = 4;            // overrun, noise, framing, parity

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_MODE   = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_CTRL3  = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_DATA   = 4'h7;

	// ************************************************************
	// tx_pin_and_error_irq_control fields
	// ************************************************************
	localparam int C3_RX_BIT8   = 7;          // rx_bit8_tx_bit9, read side
	localparam int C3_TX_BIT8   = 6;          // rx_bit9_tx_bit8, write side
	localparam int C3_TX_PIN_DIRECTION     = 5;          // tx_pin_direction
	localparam int C3_TX_POLARITY_FLIP     = 4;          // tx_polarity_flip
	localparam int C3_IRQ_EN_HI = 3;          // overrun_irq_en .. parity_irq_en
	localparam logic [DATA_W-1:0] C3_RESET = 8'h00;

	// error vector order, shared by status bits and enables
	localparam int ERR_OVERRUN = 3;
	localparam int ERR_NOISE   = 2;
	localparam int ERR_FRAMING = 1;
	localparam int ERR_PARITY  = 0;

	// ************************************************************
	// status fields
	// ************************************************************
	localparam int ST_TX_SPACE = 7;           // transmit FIFO can take a word
	localparam int ST_TX_IDLE  = 6;           // transmit path fully empty
	localparam int ST_RX_FULL  = 5;           // receive buffer holds a word

	// ************************************************************
	// mode fields
	// ************************************************************
	localparam int MD_LOOP   = 7;             // loop_mode_select
	localparam int MD_RECEIVER_SOURCE_SELECT   = 5;             // receiver_source_select
	localparam int MD_NINE   = 4;             // 9-bit characters
	localparam logic [DATA_W-1:0] MD_MASK  = 8'hb0;
	localparam logic [DATA_W-1:0] MD_RESET = 8'h00;

endpackage

// ===== rtl/utc_fifo_if.sv
/*
 * utc_fifo_if: valid/ready carrier between the register block and its
 * transmit FIFO.
 * assumes: one clock domain; push and pop each complete when valid and
 * ready are both high at a rising edge.
 */
`timescale 1ns/1ps
interface utc_fifo_if #(
	parameter int WIDTH = 9
);
	logic             push_valid;
	logic             push_ready;
	logic [WIDTH-1:0] push_data;
	logic             pop_valid;
	logic             pop_ready;
	logic [WIDTH-1:0] pop_data;

	modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
	modport fifo (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
endinterface

// ===== rtl/utc_fifo.sv
/*
 * utc_fifo: synchronous first-in first-out buffer, width and depth set
 * by parameters, valid/ready on both sides.
 * assumes: sys_clk domain, asynchronous active-high rst.
 */
`timescale 1ns/1ps
module utc_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	utc_fifo_if.fifo  port
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] PTR_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
	localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [CNT_W-1:0] count_reg;
	wire              do_push;
	wire              do_pop;

	// handshakes and honest full/empty
	assign port.push_ready = (count_reg != CNT_FULL);
	assign port.pop_valid  = (count_reg != CNT_ZERO);
	assign port.pop_data   = mem[rd_ptr_reg];
	assign do_push         = port.push_valid & port.push_ready;
	assign do_pop          = port.pop_valid & port.pop_ready;

	// storage array, no reset needed
	always_ff @(posedge sys_clk) begin
		if (do_push) begin
			mem[wr_ptr_reg] <= port.push_data;
		end
	end

	// pointers wrap at the last entry, count tracks occupancy
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= PTR_ZERO;
			rd_ptr_reg <= PTR_ZERO;
			count_reg  <= CNT_ZERO;
		end else begin
			if (do_push) begin
				wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? PTR_ZERO : wr_ptr_reg + PTR_ONE;
			end
			if (do_pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? PTR_ZERO : rd_ptr_reg + PTR_ONE;
			end
			if (do_push && !do_pop) begin
				count_reg <= count_reg + CNT_ONE;
			end else if (do_pop && !do_push) begin
				count_reg <= count_reg - CNT_ONE;
			end
		end
	end
endmodule

// ===== rtl/utc_top.sv
/*
 * utc_top: register side of a serial transceiver: transmit pin control
 * and error interrupt enables, the shared receive/transmit data port,
 * the error flags with their clearing sequence, and the transmit FIFO.
 * assumes: a framer outside takes tx words and supplies the serial level,
 * received words and per-word error events, all synchronous to sys_clk.
 */
// Local design decision: strobed register access.
// Behaviour
// - single-wire mode: direction bit 0 makes tx pin input, 1 makes it output
// - polarity bit 4 inverts every tx pin level: data, start, stop, break, idle
// - overrun enable bit 3 raises interrupt while overrun flag set
// - noise enable bit 2 raises interrupt while noise flag set
// - framing enable bit 1 raises interrupt while framing flag set
// - parity enable bit 0 raises interrupt while parity flag set
// - offset 7h reads the receive buffer and writes the transmit buffer
// - status read followed by data read clears pending receive flags
// - data port bits 7..0 map one to one onto buffer bits
// - single-wire mode only when loop and receiver-source bits both set
// - ninth bits: read before data; stored tx ninth bit goes with data write in nine-bit mode, zero otherwise
`timescale 1ns/1ps
module utc_top
	import utc_pkg::*;
(
	input  wire logic                       sys_clk,
	input  wire logic                       rst,
	input  wire logic [utc_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [utc_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [utc_pkg::DATA_W-1:0] reg_rdata,
	output logic      [utc_pkg::WORD_W-1:0] tx_word,
	output logic                            tx_word_valid,
	input  wire logic                       tx_word_ready,
	input  wire logic                       tx_busy,
	input  wire logic                       tx_line_level,
	output logic                            tx_pin_out,
	output logic                            tx_pin_oe_n,
	input  wire logic                       tx_pin_in,
	input  wire logic                       rxd_pin_in,
	output logic                            rx_line,
	input  wire logic [utc_pkg::WORD_W-1:0] rx_word,
	input  wire logic                       rx_word_valid,
	input  wire logic                       rx_noise_evt,
	input  wire logic                       rx_framing_evt,
	input  wire logic                       rx_parity_evt,
	output logic                            nine_bit_mode,
	output logic                            irq
);
	import utc_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	logic [DATA_W-1:0] ctrl3_reg;             // bit 7 unused here, receive bit 8 read separately
	logic [DATA_W-1:0] mode_reg;
	logic [DATA_W-1:0] rx_buf_reg;
	logic              rx_bit8_reg;
	logic              rx_full_reg;
	logic [ERR_N-1:0]  err_reg;
	logic              clr_armed_reg;         // status read seen, data read pending
	logic              rx_full_seen_reg;
	logic [ERR_N-1:0]  err_seen_reg;
	logic [DATA_W-1:0] reg_rdata_reg;
	logic [WORD_W-1:0] tx_word_reg;
	logic              tx_word_valid_reg;
	logic              tx_pin_out_reg;
	logic              tx_pin_oe_n_reg;
	logic              rx_line_reg;
	logic              irq_reg;

	// carrier between the data port and the transmit queue
	utc_fifo_if #(.WIDTH(WORD_W)) txq ();

	// ************************************************************
	// decode
	// ************************************************************
	// one strobe per register, qualified by its address
	wire hit_status = (reg_addr == OFS_STATUS);
	wire hit_mode   = (reg_addr == OFS_MODE);
	wire hit_ctrl3  = (reg_addr == OFS_CTRL3);
	wire hit_data   = (reg_addr == OFS_DATA);
	wire wr_mode    = reg_wr & hit_mode;
	wire wr_ctrl3   = reg_wr & hit_ctrl3;
	wire wr_data    = reg_wr & hit_data;
	wire rd_status  = reg_rd & hit_status;
	wire rd_data    = reg_rd & hit_data;

	// mode decode
	// single-wire needs loop and the external receive source together
	wire loop_mode_select       = mode_reg[MD_LOOP];
	wire receiver_source_select = mode_reg[MD_RECEIVER_SOURCE_SELECT];
	wire nine_sel               = mode_reg[MD_NINE];
	wire single_wire            = loop_mode_select & receiver_source_select;
	wire tx_pin_direction       = ctrl3_reg[C3_TX_PIN_DIRECTION];
	wire tx_polarity_flip       = ctrl3_reg[C3_TX_POLARITY_FLIP];
	wire [ERR_N-1:0] irq_en     = ctrl3_reg[C3_IRQ_EN_HI:0];

	// ************************************************************
	// receive path and flags
	// ************************************************************
	// clearing sequence: data read after a status read drops what was seen
	wire seq_clear   = rd_data & clr_armed_reg;
	wire clr_rx_full = seq_clear & rx_full_seen_reg;
	wire [ERR_N-1:0] clr_err = {ERR_N{seq_clear}} & err_seen_reg;

	// a word arriving into a still full buffer is an overrun and is dropped
	wire rx_blocked = rx_full_reg & ~clr_rx_full;
	wire rx_accept  = rx_word_valid & ~rx_blocked;
	wire overrun_ev = rx_word_valid & rx_blocked;

	wire [ERR_N-1:0] err_evt;
	assign err_evt[ERR_OVERRUN] = overrun_ev;
	assign err_evt[ERR_NOISE]   = rx_accept & rx_noise_evt;
	assign err_evt[ERR_FRAMING] = rx_accept & rx_framing_evt;
	assign err_evt[ERR_PARITY]  = rx_accept & rx_parity_evt;

	// sticky error flags, a new event wins over a clear in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < ERR_N; gi++) begin : g_err
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					err_reg[gi] <= 1'b0;
				end else if (err_evt[gi]) begin
					err_reg[gi] <= 1'b1;
				end else if (clr_err[gi]) begin
					err_reg[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// receive buffer with its ninth bit
	// the ninth bit is loaded with the byte so the pair never splits
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_buf_reg  <= '0;
			rx_bit8_reg <= 1'b0;
			rx_full_reg <= 1'b0;
		end else begin
			if (rx_accept) begin
				rx_buf_reg  <= rx_word[DATA_W-1:0];
				rx_bit8_reg <= rx_word[DATA_W];
				rx_full_reg <= 1'b1;
			end else if (clr_rx_full) begin
				rx_full_reg <= 1'b0;
			end
		end
	end

	// status read arms the sequence and remembers which flags it showed
	// a data read always disarms, so a stale snapshot never clears later flags
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clr_armed_reg    <= 1'b0;
			rx_full_seen_reg <= 1'b0;
			err_seen_reg     <= '0;
		end else if (rd_status) begin
			clr_armed_reg    <= 1'b1;
			rx_full_seen_reg <= rx_full_reg;
			err_seen_reg     <= err_reg;
		end else if (rd_data) begin
			clr_armed_reg    <= 1'b0;
			rx_full_seen_reg <= 1'b0;
			err_seen_reg     <= '0;
		end
	end

	// ************************************************************
	// control registers
	// ************************************************************
	// software writes; mode keeps only its defined bits
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl3_reg <= C3_RESET;
			mode_reg  <= MD_RESET;
		end else begin
			if (wr_ctrl3) begin
				ctrl3_reg <= reg_wdata;
			end
			if (wr_mode) begin
				mode_reg <= reg_wdata & MD_MASK;
			end
		end
	end

	// ************************************************************
	// transmit path
	// ************************************************************
	// data write pushes the byte with the stored ninth bit, zero outside nine-bit mode; dropped when full
	wire tx_bit8 = nine_sel & ctrl3_reg[C3_TX_BIT8];
	assign txq.push_valid = wr_data;
	assign txq.push_data  = {tx_bit8, reg_wdata};

	// output stage refills whenever it is empty or being taken
	wire out_free     = ~tx_word_valid_reg | tx_word_ready;
	assign txq.pop_ready = out_free;
	wire tx_space     = txq.push_ready;
	// idle only when queue, output stage and framer are all empty
	wire tx_idle      = ~txq.pop_valid & ~tx_word_valid_reg & ~tx_busy;

	// nine-bit words wait here until the output register takes them
	utc_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_txq (
		.sys_clk(sys_clk),
		.rst    (rst),
		.port   (txq.fifo)
	);

	// output register keeps tx_word steady until the framer takes it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_word_reg       <= '0;
			tx_word_valid_reg <= 1'b0;
		end else if (out_free) begin
			tx_word_reg       <= txq.pop_data;
			tx_word_valid_reg <= txq.pop_valid;
		end
	end

	// ************************************************************
	// pins and receive source
	// ************************************************************
	// inversion acts on the raw level, so idle and break flip as well
	wire pin_level_next = tx_line_level ^ tx_polarity_flip;
	wire pin_oe_n_next  = single_wire & ~tx_pin_direction;

	// loop without external source listens to its own transmitter
	wire rx_line_next = !loop_mode_select ? rxd_pin_in :
	                    receiver_source_select ? tx_pin_in : pin_level_next;

	// pin level, pin enable and receive source are all registered;
	// reset leaves the pin driven at its idle level
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_pin_out_reg  <= 1'b1;
			tx_pin_oe_n_reg <= 1'b0;
			rx_line_reg     <= 1'b1;
		end else begin
			tx_pin_out_reg  <= pin_level_next;
			tx_pin_oe_n_reg <= pin_oe_n_next;
			rx_line_reg     <= rx_line_next;
		end
	end

	// ************************************************************
	// interrupt
	// ************************************************************
	wire irq_next = |(err_reg & irq_en);

	// one flop on the request so decode glitches never reach the pin
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	// ************************************************************
	// read data
	// ************************************************************
	// status word built field by field from the shared positions
	wire [DATA_W-1:0] status_view;
	assign status_view[ST_TX_SPACE]        = tx_space;
	assign status_view[ST_TX_IDLE]         = tx_idle;
	assign status_view[ST_RX_FULL]         = rx_full_reg;
	assign status_view[ST_RX_FULL-1:ERR_N] = '0;          // unused bit between the flags
	assign status_view[ERR_N-1:0]          = err_reg;
	wire [DATA_W-1:0] ctrl3_view  = {rx_bit8_reg, ctrl3_reg[C3_TX_BIT8:0]};
	wire [DATA_W-1:0] rd_mux      = hit_status ? status_view :
	                                hit_mode   ? mode_reg :
	                                hit_ctrl3  ? ctrl3_view :
	                                hit_data   ? rx_buf_reg :
	                                             '0;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata_reg <= '0;
		end else if (reg_rd) begin
			reg_rdata_reg <= rd_mux;
		end else begin
			reg_rdata_reg <= '0;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	// every output is a flop or a flop bit
	assign reg_rdata     = reg_rdata_reg;
	assign tx_word       = tx_word_reg;
	assign tx_word_valid = tx_word_valid_reg;
	assign tx_pin_out    = tx_pin_out_reg;
	assign tx_pin_oe_n   = tx_pin_oe_n_reg;
	assign rx_line       = rx_line_reg;
	assign nine_bit_mode = mode_reg[MD_NINE];
	assign irq           = irq_reg;
endmodule

// ===== bench/utc_top_assertions.sv
/* utc_top_assertions: port-level checks of utc_top.
 * assumes: bound to utc_top; one clock, rst asynchronous active high. */
`timescale 1ns/1ps
module utc_top_assertions (
	input wire logic                       sys_clk,
	input wire logic                       rst,
	input wire logic [utc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [utc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic                       reg_wr,
	input wire logic                       reg_rd,
	input wire logic [utc_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [utc_pkg::WORD_W-1:0] tx_word,
	input wire logic                       tx_word_valid,
	input wire logic                       tx_word_ready,
	input wire logic                       tx_line_level,
	input wire logic                       tx_pin_out,
	input wire logic                       tx_pin_oe_n,
	input wire logic                       rx_word_valid,
	input wire logic                       rx_noise_evt,
	input wire logic                       rx_framing_evt,
	input wire logic                       rx_parity_evt,
	input wire logic                       nine_bit_mode,
	input wire logic                       irq
);
	import utc_pkg::*;
	// ********
	// shadow of the control registers
	// ********
	logic [7:0] c3_sh;
	logic [7:0] md_sh;
	logic       live;
	wire        wr_dt = reg_wr && reg_addr == OFS_DATA;
	wire        sw_in = md_sh[MD_LOOP] && md_sh[MD_RECEIVER_SOURCE_SELECT] && !c3_sh[C3_TX_PIN_DIRECTION];
	wire [2:0]  ev_en = {rx_noise_evt, rx_framing_evt, rx_parity_evt} & c3_sh[2:0];
	// track software writes; live marks the edges after reset release
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			c3_sh <= 8'h00;
			md_sh <= 8'h00;
			live  <= 1'h0;
		end else begin
			live <= 1'h1;
			if (reg_wr && reg_addr == OFS_CTRL3) c3_sh <= reg_wdata;
			if (reg_wr && reg_addr == OFS_MODE) md_sh <= reg_wdata & MD_MASK;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_data_wr;
		wr_dt && !tx_word_valid;
	endsequence
	sequence s_err_in;
		rx_word_valid && c3_sh[C3_IRQ_EN_HI] && (ev_en != 3'h0);
	endsequence
	a_oe_single_wire: assert property (live |-> tx_pin_oe_n == $past(sw_in))
		else $error("tx pin enable wrong");
	a_tx_invert: assert property (live |-> tx_pin_out == ($past(tx_line_level) ^ $past(c3_sh[C3_TX_POLARITY_FLIP])))
		else $error("tx pin level wrong");
	a_irq_raise: assert property (s_err_in |-> ##2 irq)
		else $error("irq missing after error");
	a_irq_needs_en: assert property (irq |-> $past(c3_sh[3:0]) != 4'h0)
		else $error("irq without enable");
	a_word_queued: assert property (s_data_wr |-> ##[1:2] tx_word_valid)
		else $error("tx word not offered");
	a_word_hold: assert property (tx_word_valid && !tx_word_ready |=> tx_word_valid && $stable(tx_word))
		else $error("tx word changed before taken");
	a_rdata_idle: assert property (live && !$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside answer cycle");
	a_ctrl_back: assert property (reg_rd && reg_addr == OFS_CTRL3 |=> reg_rdata[5:0] == $past(c3_sh[5:0]))
		else $error("control readback wrong");
	a_nine_mode: assert property (reg_wr && reg_addr == OFS_MODE |=> nine_bit_mode == $past(reg_wdata[MD_NINE]))
		else $error("nine-bit mode wrong");
endmodule

bind utc_top utc_top_assertions utc_top_assertions_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_word(tx_word),
	.tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready), .tx_line_level(tx_line_level),
	.tx_pin_out(tx_pin_out), .tx_pin_oe_n(tx_pin_oe_n), .rx_word_valid(rx_word_valid),
	.rx_noise_evt(rx_noise_evt), .rx_framing_evt(rx_framing_evt), .rx_parity_evt(rx_parity_evt),
	.nine_bit_mode(nine_bit_mode), .irq(irq));

// ===== bench/utc_far_model.sv
/* utc_far_model: framer and remote line partner of utc_top.
 * assumes: sys_clk domain; the bench stalls tx intake through hold_off. */
`timescale 1ns/1ps
module utc_far_model (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic hold_off,
	input  wire logic tx_pin_out,
	input  wire logic tx_pin_oe_n,
	output logic      tx_word_ready,
	output logic      tx_busy,
	output logic      tx_line_level,
	output logic      tx_pin_in,
	output logic      rxd_pin_in
);
	logic remote;
	// wire level: the block drives while its enable is low, else the remote end
	assign tx_pin_in = tx_pin_oe_n ? remote : tx_pin_out;
	// random intake stalls and line activity; idle level is 1
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_word_ready <= 1'h0;
			tx_busy       <= 1'h0;
			tx_line_level <= 1'h1;
			remote        <= 1'h1;
			rxd_pin_in    <= 1'h1;
		end else begin
			tx_word_ready <= !hold_off && ($urandom % 3 != 0);
			tx_busy       <= 1'($urandom);
			tx_line_level <= 1'($urandom);
			remote        <= 1'($urandom);
			rxd_pin_in    <= 1'($urandom);
		end
	end
endmodule

// ===== bench/utc_top_tb_top.sv
/* utc_top_tb_top: self-checking bench of utc_top.
 * assumes: utc_far_model stands on the framer side. */
`timescale 1ns/1ps
module utc_top_tb_top;
	import utc_pkg::*;
	logic              sys_clk = 1'h0, rst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, rd_seen = 1'h0;
	logic [3:0]        reg_addr = 4'h0;
	logic [7:0]        reg_wdata = 8'h00, reg_rdata, v;
	logic [8:0]        tx_word, rx_word = 9'h000, w;
	logic              tx_word_valid, tx_word_ready, tx_busy, tx_line_level, lv, pv, hold_off = 1'h1;
	logic              tx_pin_out, tx_pin_oe_n, tx_pin_in, rxd_pin_in, rx_line, nine_bit_mode, irq;
	logic              rx_word_valid = 1'h0, rx_noise_evt = 1'h0, rx_framing_evt = 1'h0, rx_parity_evt = 1'h0;
	logic [15:0]       exp_rd[$];
	logic [8:0]        exp_tx[$];
	logic [7:0]        en_tab[6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h0f};
	logic [2:0]        ev_tab[6] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h7, 3'h7};
	logic [7:0]        md_tab[4] = '{8'ha0, 8'ha0, 8'h80, 8'h00};
	logic [7:0]        c3_tab[4] = '{8'h00, 8'h30, 8'h10, 8'h00};
	int                bad_count = 0, samples_checked = 0, n;
	always #2 sys_clk = ~sys_clk;
	utc_top utc_top_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_word(tx_word), .tx_word_valid(tx_word_valid),
		.tx_word_ready(tx_word_ready), .tx_busy(tx_busy), .tx_line_level(tx_line_level), .tx_pin_out(tx_pin_out),
		.tx_pin_oe_n(tx_pin_oe_n), .tx_pin_in(tx_pin_in), .rxd_pin_in(rxd_pin_in), .rx_line(rx_line),
		.rx_word(rx_word), .rx_word_valid(rx_word_valid), .rx_noise_evt(rx_noise_evt),
		.rx_framing_evt(rx_framing_evt), .rx_parity_evt(rx_parity_evt), .nine_bit_mode(nine_bit_mode), .irq(irq));
	utc_far_model utc_far_model_i (.sys_clk(sys_clk), .rst(rst), .hold_off(hold_off), .tx_pin_out(tx_pin_out),
		.tx_pin_oe_n(tx_pin_oe_n), .tx_word_ready(tx_word_ready), .tx_busy(tx_busy),
		.tx_line_level(tx_line_level), .tx_pin_in(tx_pin_in), .rxd_pin_in(rxd_pin_in));
	// ********
	// tasks
	// ********
	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
		samples_checked++;
		if (ex !== got) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic tally_and_finish();
		if (bad_count == 0 && samples_checked > 0 && exp_rd.size() == 0 && exp_tx.size() == 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one bus cycle; a read notes its masked expectation
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [7:0] m);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		if (!wr) exp_rd.push_back({m, d & m});
		@(posedge sys_clk);
	endtask
	task automatic idle(input int c);
		reg_wr <= 1'h0;
		reg_rd <= 1'h0;
		repeat (c) @(posedge sys_clk);
	endtask
	task automatic rx(input logic [8:0] wd, input logic [2:0] ev);
		rx_word <= wd;
		rx_word_valid <= 1'h1;
		{rx_noise_evt, rx_framing_evt, rx_parity_evt} <= ev;
		@(posedge sys_clk);
		rx_word_valid <= 1'h0;
		{rx_noise_evt, rx_framing_evt, rx_parity_evt} <= 3'h0;
		@(posedge sys_clk);
	endtask
	task automatic drain();
		n = 0;
		while (exp_tx.size() > 0 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 300) begin
			bad_count++;
			tally_and_finish();
		end
	endtask
	// monitor: each read answer and each taken tx word meets its oldest note
	always @(posedge sys_clk) begin
		if (rd_seen) chk("read data", exp_rd.size() ? exp_rd[0] : 16'hffff, {exp_rd[0][15:8], reg_rdata & exp_rd[0][15:8]});
		if (rd_seen && exp_rd.size()) void'(exp_rd.pop_front());
		if (tx_word_valid && tx_word_ready) chk("tx word", exp_tx.size() ? {7'h00, exp_tx.pop_front()} : 16'hffff, {7'h00, tx_word});
		rd_seen = reg_rd;
	end
	// ********
	// main sequence
	// ********
	initial begin
		rst = 1'h1;
		void'($urandom(70));
		repeat (3) @(posedge sys_clk);
		rst <= 1'h0;
		bus(0, OFS_CTRL3, 8'h00, 8'hff);
		bus(0, OFS_MODE, 8'h00, 8'hff);
		v = $urandom;
		bus(1, OFS_CTRL3, v, 8'h00);
		bus(0, OFS_CTRL3, v, 8'h3f);
		bus(1, OFS_MODE, v, 8'h00);
		bus(0, OFS_MODE, v & MD_MASK, 8'hff);
		bus(1, 4'h2, v, 8'h00);
		bus(0, 4'h2, 8'h00, 8'hff);
		for (int i = 0; i < 6; i++) begin
			bus(1, OFS_CTRL3, en_tab[i], 8'h00);
			idle(1);
			w = $urandom;
			rx(w, ev_tab[i]);
			if (i == 3) rx(~w, 3'h0);
			@(posedge sys_clk);
			chk("irq", {15'h0, en_tab[i] != 8'h00}, {15'h0, irq});
			bus(0, OFS_STATUS, (i == 3) ? 8'ha8 : {5'h14, ev_tab[i]}, 8'hbf);
			bus(0, OFS_CTRL3, {w[8], 7'h00}, 8'h80);
			bus(0, OFS_DATA, w[7:0], 8'hff);
			idle(2);
			chk("irq clear", 16'h0000, {15'h0, irq});
			bus(0, OFS_STATUS, 8'h80, 8'hbf);
			idle(1);
		end
		bus(1, OFS_MODE, 8'h10, 8'h00);
		bus(1, OFS_CTRL3, 8'h40, 8'h00);
		for (int k = 0; k < 10; k++) begin
			v = $urandom;
			bus(1, OFS_DATA, v, 8'h00);
			if (k < 9) exp_tx.push_back({1'h1, v});
		end
		bus(0, OFS_STATUS, 8'h00, 8'h80);
		idle(1);
		hold_off <= 1'h0;
		drain();
		bus(1, OFS_MODE, 8'h00, 8'h00);
		v = $urandom;
		bus(1, OFS_DATA, v, 8'h00);
		exp_tx.push_back({1'h0, v});
		idle(1);
		drain();
		bus(0, OFS_STATUS, 8'h80, 8'h80);
		for (int k = 0; k < 4; k++) begin
			bus(1, OFS_MODE, md_tab[k], 8'h00);
			bus(1, OFS_CTRL3, c3_tab[k], 8'h00);
			idle(2);
			chk("pin enable", {15'h0, k == 0}, {15'h0, tx_pin_oe_n});
			lv = tx_line_level;
			pv = (k == 3) ? rxd_pin_in : (k == 2) ? (lv ^ c3_tab[k][4]) : tx_pin_in;
			@(posedge sys_clk);
			chk("pin level", {15'h0, lv ^ c3_tab[k][4]}, {15'h0, tx_pin_out});
			chk("rx line", {15'h0, pv}, {15'h0, rx_line});
		end
		idle(4);
		tally_and_finish();
	end
endmodule
